// ===== swm_dev_model.sv
`timescale 1ns/1ns
// Behavioural far-side device: answers resets, samples writes, drives read bits
module swm_dev_model
   import swm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       line,
   input  wire logic       tx_en,
   input  wire logic [7:0] tx_byte,
   output logic            pull,
   output logic            fast,
   output logic [7:0]      rx_byte
);
   logic        line_q;  // Line level one cycle ago
   logic        pend;    // Fast mode requested, applied at slot end
   logic [15:0] low_cnt; // Length of the master's low run
   logic [15:0] since;   // Cycles since the slot's falling edge
   logic [2:0]  bitn;    // Bit position within the byte
   logic [1:0]  st;      // 0 slots, 1 presence wait, 2 presence low
   wire         fall = line_q & ~line;
   wire         rise = ~line_q & line;
   wire  [15:0] dly  = fast ? 16'h0064 : 16'h02EE;
   wire  [15:0] thr  = fast ? 16'h0190 : 16'h0BB8;
   wire  [15:0] pdh  = fast ? 16'h004B : 16'h02EE;
   wire  [15:0] pdl  = fast ? 16'h012C : 16'h0BB8;
   wire  [7:0]  shin = {line, rx_byte[7:1]};

   // All line timing counted on this clock from edges
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         line_q  <= 1'b1;
         pend    <= 1'b0;
         fast    <= 1'b0;
         pull    <= 1'b0;
         low_cnt <= 16'h0000;
         since   <= 16'hFFFF;
         bitn    <= 3'd0;
         st      <= 2'd0;
         rx_byte <= 8'h00;
      end
      else
      begin
         line_q  <= line;
         // Own pulls do not count as a master reset
         low_cnt <= (line | pull) ? 16'h0000 : low_cnt + 16'h0001;
         if (rise && low_cnt > thr)
         begin
            // A long reset leaves fast mode, a short one keeps it
            st    <= 2'd1;
            since <= 16'h0000;
            bitn  <= 3'd0;
            fast  <= (low_cnt > 16'h07D0) ? 1'b0 : pend;
            pend  <= (low_cnt > 16'h07D0) ? 1'b0 : pend;
         end
         else if (st != 2'd0)
         begin
            // Wait, then presence pulse; only this is started by us
            since <= since + 16'h0001;
            if (st == 2'd1 && since == pdh)
            begin
               st    <= 2'd2;
               pull  <= 1'b1;
               since <= 16'h0000;
            end
            if (st == 2'd2 && since == pdl)
            begin
               st   <= 2'd0;
               pull <= 1'b0;
            end
         end
         else if (fall)
         begin
            // Falling edge arms the delay; a zero read bit is held low
            since <= 16'h0001;
            pull  <= tx_en & ~tx_byte[bitn];
         end
         else
         begin
            since <= (since == 16'hFFFF) ? since : since + 16'h0001;
            // Speed only changes between slots, else a slot would be cut short
            fast  <= rise ? pend : fast;
            if (since == dly)
            begin
               pull    <= 1'b0;
               bitn    <= bitn + 3'd1;
               rx_byte <= tx_en ? rx_byte : shin;
               pend    <= pend | (!tx_en && bitn == 3'd7 && shin == CMD_FAST_SKIP);
            end
         end
      end
   end
endmodule

// ===== swm_master.sv
`timescale 1ns/1ns
// Bus master engine: resets the line and moves bytes through time slots
module swm_master
   import swm_pkg::*;
#(
   parameter int RSTL_REG  = C_RSTL_REG,
   parameter int PRES_REG  = C_PRES_REG
)
(
   input  wire logic     clk,
   input  wire logic     rst_n,
   input  wire logic     req_valid,
   output logic          req_ready,
   input  wire swm_req_s req,
   output logic          rsp_valid,
   output swm_rsp_s      rsp,
   output logic          fast_mode_flag,
   input  wire logic     line_in,
   output logic          line_out,
   output logic          line_oe
);
   swm_state_e         state_reg;        // Engine state
   swm_state_e         state_next;
   logic [CNT_W-1:0]   cnt_reg;          // Cycles into current phase
   logic [2:0]         bit_reg;          // Bit index in byte, lsb first
   logic [7:0]         sh_reg;           // Byte shifting out and in
   swm_op_e            op_reg;           // Operation in progress
   logic               pres_seen_reg;    // Line pulled low by a device
   logic               fast_reg;         // Our fast-mode flag copy
   logic               rsp_valid_reg;
   logic [7:0]         data_reg;
   logic               pres_reg;
   logic [15:0]        crc16_reg;        // Running 16-bit code
   logic [7:0]         crc8_reg;         // Running identity code

   // Phase limits follow the current speed
   wire [CNT_W-1:0] lim_rstl = fast_reg ? CNT_W'(C_RSTL_FAST) : CNT_W'(RSTL_REG);
   wire [CNT_W-1:0] lim_pres = fast_reg ? CNT_W'(C_PRES_FAST) : CNT_W'(PRES_REG);
   wire [CNT_W-1:0] lim_slot = fast_reg ? CNT_W'(C_SLOT_FAST) : CNT_W'(C_SLOT_REG);
   wire [CNT_W-1:0] lim_rdv  = fast_reg ? CNT_W'(C_RDV_FAST) : CNT_W'(C_RDV_REG);
   wire             cur_bit  = sh_reg[0];
   // Write one and read release early; write zero holds the whole slot
   wire             short_low = (op_reg == SWM_OP_READ) || cur_bit;
   wire [CNT_W-1:0] lim_low  = short_low ? CNT_W'(C_LOW1) : lim_slot;
   wire             phase_end = (cnt_reg == lim_low - 1'b1);
   wire             samp_now  = (state_reg == SWM_HOLD) && (cnt_reg == lim_rdv - 1'b1);
   wire             rx_bit    = (op_reg == SWM_OP_READ) ? line_in : cur_bit;
   wire             accept    = req_valid && req_ready;
   wire             byte_done = (state_reg == SWM_REC) && (cnt_reg == CNT_W'(C_REC - 1))
                                && (bit_reg == 3'd7);
   wire [15:0]      crc16_fb  = {15'h0000, crc16_reg[0] ^ rx_bit};
   wire [7:0]       crc8_fb   = {7'h00, crc8_reg[0] ^ rx_bit};
   wire [15:0]      crc16_nx  = (crc16_reg >> 1) ^ (CRC16_POLY & {16{crc16_fb[0]}});
   wire [7:0]       crc8_nx   = (crc8_reg >> 1) ^ (CRC8_POLY & {8{crc8_fb[0]}});
   // Speed switches only once the whole command byte is out, never inside a slot
   wire             fast_cmd  = (op_reg == SWM_OP_WRITE) && (sh_reg == CMD_FAST_SKIP);

   assign req_ready      = (state_reg == SWM_IDLE);
   assign rsp_valid      = rsp_valid_reg;
   // Running codes go out raw so the user can compare and re-read on error
   assign rsp            = '{data: data_reg, presence: pres_reg,
                             crc16: crc16_reg, crc8: crc8_reg};
   assign fast_mode_flag = fast_reg;
   assign line_out       = 1'b0;
   // Drive low only in reset and slot low phases; released otherwise
   assign line_oe        = (state_reg == SWM_RST_LOW) || (state_reg == SWM_LOW);

   // Next state
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         SWM_IDLE:
            if (accept && req.op == SWM_OP_RESET)
               state_next = SWM_RST_LOW;
            else if (accept && req.op != SWM_OP_CLR)
               state_next = SWM_LOW;
         SWM_RST_LOW:
            if (cnt_reg == lim_rstl - 1'b1)
               state_next = SWM_PRES;
         SWM_PRES:
            if (cnt_reg == lim_pres - 1'b1)
               state_next = SWM_IDLE;
         SWM_LOW:
            if (phase_end)
               state_next = SWM_HOLD;
         SWM_HOLD:
            if (cnt_reg == lim_slot - 1'b1)
               state_next = SWM_REC;
         SWM_REC:
            if (cnt_reg == CNT_W'(C_REC - 1))
               state_next = (bit_reg == 3'd7) ? SWM_IDLE : SWM_LOW;
         default:
            state_next = SWM_IDLE;
      endcase
   end

   // State and phase counter
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= SWM_IDLE;
         cnt_reg   <= '0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= (state_next != state_reg) ? '0 : cnt_reg + 1'b1;
      end
   end

   // Byte shifter, bit index and operation latch
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sh_reg  <= '0;
         bit_reg <= '0;
         op_reg  <= SWM_OP_RESET;
      end
      else if (accept)
      begin
         sh_reg  <= req.data;
         bit_reg <= '0;
         op_reg  <= req.op;
      end
      else if (samp_now)
         sh_reg  <= {rx_bit, sh_reg[7:1]};
      else if (state_reg == SWM_REC && state_next == SWM_LOW)
         bit_reg <= bit_reg + 1'b1;
   end

   // Check codes: host clears before each pass, then every bit is folded in
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         crc16_reg <= CRC16_INIT;
         crc8_reg  <= '0;
      end
      else if (accept && req.op == SWM_OP_CLR)
      begin
         crc16_reg <= CRC16_INIT;
         crc8_reg  <= '0;
      end
      else if (samp_now)
      begin
         crc16_reg <= crc16_nx;
         crc8_reg  <= crc8_nx;
      end
   end

   // Presence sampling, speed flag and answer
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pres_seen_reg <= 1'b0;
         fast_reg      <= 1'b0;
         rsp_valid_reg <= 1'b0;
         data_reg      <= '0;
         pres_reg      <= 1'b0;
      end
      else
      begin
         rsp_valid_reg <= 1'b0;
         if (state_reg == SWM_RST_LOW)
            pres_seen_reg <= 1'b0;
         else if (state_reg == SWM_PRES && !line_in)
            pres_seen_reg <= 1'b1;
         // A regular-length reset returns everyone to regular speed
         if (state_reg == SWM_RST_LOW && state_next == SWM_PRES
             && cnt_reg >= CNT_W'(C_RSTL_REG - 1))
            fast_reg <= 1'b0;
         else if (byte_done && fast_cmd)
            fast_reg <= 1'b1;
         if (state_reg == SWM_PRES && state_next == SWM_IDLE)
         begin
            rsp_valid_reg <= 1'b1;
            pres_reg      <= pres_seen_reg || !line_in;
         end
         else if (byte_done)
         begin
            rsp_valid_reg <= 1'b1;
            data_reg      <= sh_reg;
         end
         else if (accept && req.op == SWM_OP_CLR)
            rsp_valid_reg <= 1'b1;
      end
   end

   // Reset low stays under the interrupt-masking limit
   rst_max_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg == SWM_RST_LOW |-> cnt_reg < CNT_W'(C_RSTL_MAX))
      else $error("reset low too long");
   rst_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state_reg == SWM_RST_LOW) && !fast_reg |-> (line_oe) [*8])
      else $error("reset pulse cut short");
   slot_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state_reg == SWM_LOW) |-> line_oe && !line_out)
      else $error("slot not started low");
   read_rel_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg == SWM_HOLD && op_reg == SWM_OP_READ |-> !line_oe)
      else $error("master drives during read");
   pres_rel_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg == SWM_PRES |-> !line_oe)
      else $error("line not released for presence");
   fast_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(fast_reg) |-> $past(state_reg) == SWM_RST_LOW)
      else $error("fast mode left outside reset");
   fast_set_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(fast_reg) |-> $past(byte_done) && $past(op_reg) == SWM_OP_WRITE
                          && $past(sh_reg) == CMD_FAST_SKIP)
      else $error("fast mode set without command");
   crc_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
      accept && req.op == SWM_OP_CLR |=> crc16_reg == CRC16_INIT && rsp_valid)
      else $error("check code not cleared");
   busy_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg != SWM_IDLE |=> $stable(op_reg))
      else $error("request taken while busy");
   slot_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      state_reg == SWM_LOW |-> cnt_reg < lim_slot)
      else $error("slot low phase too long");
   cv_reset_c: cover property (@(posedge clk) rsp_valid && rsp.presence);
   cv_write_c: cover property (@(posedge clk) byte_done && op_reg == SWM_OP_WRITE);
   cv_read_c: cover property (@(posedge clk) byte_done && op_reg == SWM_OP_READ);
   cv_fast_c: cover property (@(posedge clk) $rose(fast_reg));
endmodule

// ===== swm_pkg.sv
package swm_pkg;
   localparam int CLK_MHZ        = 25;
   // Times in microseconds
   localparam int T_RST_LOW_REG_US    = 480;
   localparam int T_RST_LOW_FAST_US   = 48;
   localparam int T_RST_LOW_MAX_US    = 960;
   localparam int T_PRES_WAIT_REG_US  = 60;
   localparam int T_PRES_WAIT_FAST_US = 6;
   localparam int T_PRES_LOW_REG_US   = 240;
   localparam int T_PRES_LOW_FAST_US  = 24;
   localparam int T_SLOT_REG_US  = 60;
   localparam int T_SLOT_FAST_US = 6;
   localparam int T_LOW1_US      = 1;
   localparam int T_RDV_REG_US   = 15;
   localparam int T_RDV_FAST_US  = 2;
   localparam int T_REC_US       = 1;
   // Cycle counts derived from the clock rate
   localparam int C_RSTL_REG  = T_RST_LOW_REG_US * CLK_MHZ;
   localparam int C_RSTL_FAST = T_RST_LOW_FAST_US * CLK_MHZ;
   localparam int C_RSTL_MAX  = T_RST_LOW_MAX_US * CLK_MHZ;
   // Presence window covers the slowest legal answer: longest wait plus longest pulse
   localparam int C_PRES_REG  = (T_PRES_WAIT_REG_US + T_PRES_LOW_REG_US) * CLK_MHZ;
   localparam int C_PRES_FAST = (T_PRES_WAIT_FAST_US + T_PRES_LOW_FAST_US) * CLK_MHZ;
   localparam int C_SLOT_REG  = T_SLOT_REG_US * CLK_MHZ;
   localparam int C_SLOT_FAST = T_SLOT_FAST_US * CLK_MHZ;
   localparam int C_LOW1      = T_LOW1_US * CLK_MHZ;
   localparam int C_RDV_REG   = T_RDV_REG_US * CLK_MHZ;
   localparam int C_RDV_FAST  = T_RDV_FAST_US * CLK_MHZ;
   localparam int C_REC       = T_REC_US * CLK_MHZ;
   localparam int CNT_W       = 16;
   // Check code constants and the fast-mode command code
   localparam logic [15:0] CRC16_POLY = 16'hA001;
   localparam logic [7:0]  CRC8_POLY  = 8'h8C;
   localparam logic [15:0] CRC16_INIT = 16'h0000;
   localparam logic [7:0]  CMD_FAST_SKIP = 8'h3C;
   // Command codes of the host port
   typedef enum logic [1:0] {SWM_OP_RESET, SWM_OP_WRITE, SWM_OP_READ, SWM_OP_CLR} swm_op_e;
   typedef struct packed {
      swm_op_e    op;
      logic [7:0] data;
   } swm_req_s;
   typedef struct packed {
      logic [7:0]  data;
      logic        presence;
      logic [15:0] crc16;
      logic [7:0]  crc8;
   } swm_rsp_s;
   typedef enum {SWM_IDLE, SWM_RST_LOW, SWM_PRES, SWM_LOW, SWM_HOLD, SWM_REC} swm_state_e;
endpackage

// ===== tb.sv
`timescale 1ns/1ns
// Self-checking bench: master engine against the behavioural device
module tb
   import swm_pkg::*;
;
   logic        clk, rst_n, por_n, req_valid, tx_en, req_ready, rsp_valid;
   logic        fast_mode_flag, line_out, line_oe, dev_pull, dev_fast;
   logic [7:0]  tx_byte, rx_byte;
   logic [15:0] oe_cnt, last_low;  // Length of the master's last low drive
   swm_req_s    req;
   swm_rsp_s    rsp;
   int          miscompares, checks;
   // Open-drain line with pull-up: low while either party pulls
   wire         line = ~((line_oe & ~line_out) | dev_pull);

   swm_master dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .fast_mode_flag(fast_mode_flag),
      .line_in(line), .line_out(line_out), .line_oe(line_oe));
   swm_dev_model dev (.clk(clk), .rst_n(por_n), .line(line), .tx_en(tx_en),
      .tx_byte(tx_byte), .pull(dev_pull), .fast(dev_fast), .rx_byte(rx_byte));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Measured on the falling edge, away from the launching edge
   always @(negedge clk)
   begin
      if (line_oe === 1'b1)
         oe_cnt <= oe_cnt + 16'h0001;
      else if (oe_cnt != 16'h0000)
      begin
         last_low <= oe_cnt;
         oe_cnt   <= 16'h0000;
      end
   end

   function automatic logic [15:0] c16(input logic [15:0] c, input logic [7:0] d);
      for (int i = 0; i < 8; i++)
         c = (c[0] ^ d[i]) ? (c >> 1) ^ CRC16_POLY : c >> 1;
      return c;
   endfunction

   function automatic logic [7:0] c8(input logic [7:0] c, input logic [7:0] d);
      for (int i = 0; i < 8; i++)
         c = (c[0] ^ d[i]) ? (c >> 1) ^ CRC8_POLY : c >> 1;
      return c;
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One request, then a bounded wait for its answer
   task automatic op(input swm_op_e o, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req       <= '{op: o, data: d};
      @(posedge clk);
      req_valid <= 1'b0;
      @(negedge clk);
      while (rsp_valid !== 1'b1 && n < 30000)
      begin
         @(negedge clk);
         n++;
      end
      chk({15'h0000, rsp_valid}, 16'h0001);
      chk({15'h0000, req_ready}, 16'h0001);
   endtask

   task automatic give_verdict;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic t_reg_reset;
      op(SWM_OP_RESET, 8'h00);
      chk({15'h0000, rsp.presence}, 16'h0001);
      chk({15'h0000, last_low >= C_RSTL_REG && last_low < C_RSTL_MAX}, 16'h0001);
      chk({15'h0000, fast_mode_flag}, 16'h0000);
      chk({15'h0000, dev_fast}, 16'h0000);
      $display("test reg_reset done");
   endtask

   task automatic t_enter_fast;
      op(SWM_OP_WRITE, CMD_FAST_SKIP);
      chk({8'h00, rx_byte}, {8'h00, CMD_FAST_SKIP});
      chk({15'h0000, fast_mode_flag}, 16'h0001);
      chk({15'h0000, dev_fast}, 16'h0001);
      $display("test enter_fast done");
   endtask

   task automatic t_fast_reset;
      op(SWM_OP_RESET, 8'h00);
      chk({15'h0000, rsp.presence}, 16'h0001);
      chk({15'h0000, last_low >= C_RSTL_FAST && last_low <= 2000}, 16'h0001);
      chk({15'h0000, dev_fast}, 16'h0001);
      $display("test fast_reset done");
   endtask

   task automatic t_fast_write;
      op(SWM_OP_WRITE, 8'h81);
      chk({8'h00, rx_byte}, 16'h0081);
      $display("test fast_write done");
   endtask

   // Data byte then the inverted code bytes, as the device would send them
   task automatic t_fast_read;
      logic [15:0] e16, code;
      logic [7:0]  e8, b;
      e16  = CRC16_INIT;
      e8   = 8'h00;
      code = c16(CRC16_INIT, 8'hA5);
      op(SWM_OP_CLR, 8'h00);
      for (int i = 0; i < 3; i++)
      begin
         b = (i == 0) ? 8'hA5 : (i == 1) ? ~code[7:0] : ~code[15:8];
         @(posedge clk);
         tx_byte <= b;
         tx_en   <= 1'b1;
         op(SWM_OP_READ, 8'h00);
         e16 = c16(e16, b);
         e8  = c8(e8, b);
         chk({8'h00, rsp.data}, {8'h00, b});
         chk(rsp.crc16, e16);
         chk({8'h00, rsp.crc8}, {8'h00, e8});
      end
      @(posedge clk);
      tx_en <= 1'b0;
      $display("test fast_read done");
   endtask

   // Identity-style pass: one byte then its 8-bit code in true form leaves zero
   task automatic t_ident_code;
      op(SWM_OP_CLR, 8'h00);
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk);
         tx_byte <= (i == 0) ? 8'h96 : c8(8'h00, 8'h96);
         tx_en   <= 1'b1;
         op(SWM_OP_READ, 8'h00);
      end
      @(posedge clk);
      tx_en <= 1'b0;
      chk({8'h00, rsp.crc8}, 16'h0000);
      $display("test ident_code done");
   endtask

   // Scratchpad-style pass: command, both addresses, one byte at offset 11111b,
   // then the inverted code; with that folded in the residue is a fixed value
   task automatic t_fast_code;
      logic [31:0] wr;
      logic [15:0] code;
      wr   = 32'h5A00_1F0F;
      code = CRC16_INIT;
      op(SWM_OP_CLR, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         op(SWM_OP_WRITE, wr[8*i +: 8]);
         code = c16(code, wr[8*i +: 8]);
         chk({8'h00, rx_byte}, {8'h00, wr[8*i +: 8]});
      end
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk);
         tx_byte <= ~code[8*i +: 8];
         tx_en   <= 1'b1;
         op(SWM_OP_READ, 8'h00);
         chk({8'h00, rsp.data}, {8'h00, ~code[8*i +: 8]});
      end
      @(posedge clk);
      tx_en <= 1'b0;
      chk(rsp.crc16, 16'hB001);
      $display("test fast_code done");
   endtask

   // Master restarts at regular speed; its long reset must pull the device back
   task automatic t_long_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk({15'h0000, fast_mode_flag}, 16'h0000);
      chk({15'h0000, dev_fast}, 16'h0001);
      t_reg_reset;
      $display("test long_reset done");
   endtask

   initial
   begin
      rst_n       = 1'b0;
      por_n       = 1'b0;
      req_valid   = 1'b0;
      req         = '{op: SWM_OP_CLR, data: 8'h00};
      tx_en       = 1'b0;
      tx_byte     = 8'h00;
      oe_cnt      = 16'h0000;
      last_low    = 16'h0000;
      miscompares = 0;
      checks      = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      t_reg_reset;
      t_enter_fast;
      t_fast_reset;
      t_fast_write;
      t_fast_read;
      t_ident_code;
      t_fast_code;
      t_long_reset;
      give_verdict;
   end

   // Expected run is about 82000 cycles
   initial
   begin
      repeat (98000) @(posedge clk);
      miscompares++;
      give_verdict;
   end
endmodule
